//--- pkg/pbm_defines.svh
// Constants for the pixel bus input mux: widths, field positions, taps.
// Assumes inclusion by its bare name from the package and the design.
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH

`define PBM_WORD_W     24
`define PBM_HALF_W     12
`define PBM_CFG_MSB    23
`define PBM_CFG_LSB    16
`define PBM_CFG_W      8
`define PBM_SKEW_W     3
`define PBM_TAPS       8
`define PBM_CTL_W      2
`define PBM_LINK_NS    320
`define PBM_CORE_NS    40

`endif

//--- pkg/pbm_pkg.sv
// Types shared by the pixel bus input mux.
// Assumes the constants header is on the include path.
`include "pbm_defines.svh"

package pbm_pkg;

   typedef enum logic [1:0] {
      PBM_MODE_SIDEBAND = 2'b00,
      PBM_MODE_SKEW     = 2'b01,
      PBM_MODE_ADDRESS  = 2'b10
   } pbm_mode_type;

   typedef enum logic {
      PBM_HALF_FIRST  = 1'b0,
      PBM_HALF_SECOND = 1'b1
   } pbm_half_type;

endpackage : pbm_pkg

//--- rtl/pbm_pixel_bus_input_mux.sv
// Input side of a flat-panel video transmitter: pixel bus capture in
// single-edge or dual-edge layout, multifunction pin routing and the
// user configuration byte.
// Assumes all pins but i_pixel_ready are asynchronous to i_core_clk, which must run at least
// four times faster than the pixel input clock.
//
// Overview of operation
// R1: Serial port off, skew off: inputs 2 and 1 become sideband control.
// R2: Sideband control is forwarded only while active video is low.
// R3: In sideband configuration multifunction input 3 is ignored.
// R4: Serial port off, skew on: three inputs form a capture-delay skew code.
// R5: Serial port on: three inputs are slave address low bits, any skew.
// R6: An undriven multifunction input reads as low.
// R7: Bus width high: upper twelve data bits captured on one edge.
// R8: Bus width high: lower twelve bits captured with the upper half.
// R9: Bus width low: lower twelve bits captured on both clock edges.
// R10: Bus width low: upper twelve data inputs give no pixel data.
// R11: Bus width low: data bits 23 to 16 copied into the user byte.
// R12: The user configuration byte is readable by the controller.
// R13: Dual-edge halves pair rising then falling into one word.
`timescale 1ns/1ns
`include "pbm_defines.svh"

module pbm_pixel_bus_input_mux
   import pbm_pkg::*;
#(
   parameter bit FIRST_HALF_LOW = 1'b1      // Rising-edge half goes low.
) (
   input  wire logic                   i_core_clk,            // Core clock.
   input  wire logic                   i_rst_b,               // Async reset.
   input  wire logic                   i_pixel_input_clock,   // Link clock.
   input  wire logic [`PBM_WORD_W-1:0] i_data,                // Pixel bus.
   input  wire logic                   i_active_video_flag,   // Active video.
   input  wire logic                   i_bus_width_select,    // 1 = 24 bit.
   input  wire logic                   i_serial_port_select,  // Serial on.
   input  wire logic                   i_skew_adjust_enable,  // Skew on.
   input  wire logic                   i_multifunction_input_1, // MF pin 1.
   input  wire logic                   i_multifunction_input_2, // MF pin 2.
   input  wire logic                   i_multifunction_input_3, // MF pin 3.
   input  wire logic                   i_pixel_ready,         // Sink ready.
   output logic [`PBM_WORD_W-1:0]      o_pixel_data,          // Pixel word.
   output logic                        o_pixel_active,        // Word's flag.
   output logic                        o_pixel_valid,         // Word valid.
   output logic                        o_overflow,            // Sticky loss.
   output logic [`PBM_CTL_W-1:0]       o_sideband_control_bits, // Sideband.
   output logic                        o_sideband_valid,      // Sideband ok.
   output logic [`PBM_SKEW_W-1:0]      o_skew_code,           // Skew in use.
   output logic [`PBM_SKEW_W-1:0]      o_slave_addr_lsb,      // Address LSBs.
   output logic [`PBM_CFG_W-1:0]       o_user_config_byte     // User byte.
);

   // ********************************************************************
   // Reset release and input synchronisers
   // ********************************************************************

   logic                     rst_meta_b;
   logic                     rst_b;
   localparam int PIN_W = `PBM_WORD_W + 8;
   logic [PIN_W-1:0]         pin_meta;
   logic [PIN_W-1:0]         pin_sync;
   logic                     clk_prev;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_b <= 1'b0;
         rst_b      <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_b      <= rst_meta_b;
      end
   end

   // Undriven multifunction pins are held low by pad pulldowns, so a
   // floating pin always arrives here as zero. [R6]
   always_ff @(posedge i_core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta <= '0;
         pin_sync <= '0;
         clk_prev <= 1'b0;
      end else begin
         pin_meta <= {i_pixel_input_clock, i_active_video_flag,
                      i_bus_width_select, i_serial_port_select,
                      i_skew_adjust_enable, i_multifunction_input_3,
                      i_multifunction_input_2, i_multifunction_input_1,
                      i_data};
         pin_sync <= pin_meta;
         clk_prev <= pin_sync[PIN_W-1];
      end
   end

   logic                     link_clk;
   logic                     de;
   logic                     wide;
   logic                     serial_on;
   logic                     skew_on;
   logic [`PBM_SKEW_W-1:0]   mf;
   logic [`PBM_WORD_W-1:0]   data;
   logic                     rise;
   logic                     fall;

   assign link_clk  = pin_sync[PIN_W-1];
   assign de        = pin_sync[PIN_W-2];
   assign wide      = pin_sync[PIN_W-3];
   assign serial_on = pin_sync[PIN_W-4];
   assign skew_on   = pin_sync[PIN_W-5];
   assign mf        = pin_sync[`PBM_WORD_W+2:`PBM_WORD_W];
   assign data      = pin_sync[`PBM_WORD_W-1:0];
   assign rise      = link_clk & ~clk_prev;
   assign fall      = ~link_clk & clk_prev;

   // ********************************************************************
   // Multifunction routing
   // ********************************************************************

   pbm_mode_type             mode;
   logic [`PBM_SKEW_W-1:0]   skew;

   always_comb begin
      if (serial_on) begin
         mode = PBM_MODE_ADDRESS;                               // [R5]
      end else if (skew_on) begin
         mode = PBM_MODE_SKEW;                                  // [R4]
      end else begin
         mode = PBM_MODE_SIDEBAND;                              // [R1]
      end
   end

   assign skew = (mode == PBM_MODE_SKEW) ? mf : '0;             // [R4]

   always_ff @(posedge i_core_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_sideband_control_bits <= '0;
         o_sideband_valid        <= 1'b0;
         o_skew_code             <= '0;
         o_slave_addr_lsb        <= '0;
      end else begin
         o_skew_code <= skew;
         if (mode == PBM_MODE_ADDRESS) begin
            o_slave_addr_lsb <= mf;                             // [R5]
         end
         // Input 3 is never looked at for the sideband bits or their valid flag. [R3]
         o_sideband_valid <= (mode == PBM_MODE_SIDEBAND) && !de;  // [R2]
         if (mode == PBM_MODE_SIDEBAND && !de) begin
            o_sideband_control_bits <= mf[`PBM_CTL_W-1:0];     // [R1] [R2]
         end
      end
   end

   // ********************************************************************
   // Skewed capture point
   // ********************************************************************

   // The skew code delays the capture strobe by whole core cycles after
   // the sampled edge; data keeps flowing, so later samples are taken.
   // Codes beyond a half link period would reach into the next half.
   logic [`PBM_TAPS-1:0]     rise_hist;
   logic [`PBM_TAPS-1:0]     fall_hist;

   function automatic logic pick_tap(input logic [`PBM_TAPS-1:0] hist,
                                     input logic [`PBM_SKEW_W-1:0] sel);
      pick_tap = hist[sel];
   endfunction : pick_tap

   always_ff @(posedge i_core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rise_hist <= '0;
         fall_hist <= '0;
      end else begin
         rise_hist <= {rise_hist[`PBM_TAPS-2:0], rise};
         fall_hist <= {fall_hist[`PBM_TAPS-2:0], fall};
      end
   end

   logic                     cap_rise;
   logic                     cap_fall;

   assign cap_rise = (skew == '0) ? rise
                   : pick_tap(rise_hist, skew - 3'h1);          // [R4]
   assign cap_fall = (skew == '0) ? fall
                   : pick_tap(fall_hist, skew - 3'h1);          // [R4]

   // ********************************************************************
   // Pixel capture and half pairing
   // ********************************************************************

   pbm_half_type             half;
   logic [`PBM_HALF_W-1:0]   first_half;
   logic                     word_push;
   logic [`PBM_WORD_W-1:0]   word;
   logic                     word_de;

   always_ff @(posedge i_core_clk or negedge rst_b) begin
      if (!rst_b) begin
         half       <= PBM_HALF_FIRST;
         first_half <= '0;
         word_push  <= 1'b0;
         word       <= '0;
         word_de    <= 1'b0;
      end else begin
         word_push <= 1'b0;
         if (wide) begin
            half <= PBM_HALF_FIRST;
            if (cap_rise) begin
               word      <= data;                               // [R7] [R8]
               word_de   <= de;
               word_push <= 1'b1;
            end
         end else begin
            unique case (half)
               PBM_HALF_FIRST: begin
                  if (cap_rise) begin
                     first_half <= data[`PBM_HALF_W-1:0];       // [R9] [R10]
                     half       <= PBM_HALF_SECOND;
                  end
               end
               PBM_HALF_SECOND: begin
                  if (cap_fall) begin
                     word      <= FIRST_HALF_LOW                // [R13]
                                ? {data[`PBM_HALF_W-1:0], first_half}
                                : {first_half, data[`PBM_HALF_W-1:0]};
                     word_de   <= de;
                     word_push <= 1'b1;
                     half      <= PBM_HALF_FIRST;
                  end
               end
            endcase
         end
      end
   end

   // ********************************************************************
   // User configuration byte
   // ********************************************************************

   always_ff @(posedge i_core_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_user_config_byte <= '0;
      end else if (!wide) begin
         o_user_config_byte <= data[`PBM_CFG_MSB:`PBM_CFG_LSB]; // [R11] [R12]
      end
   end

   // ********************************************************************
   // Two-entry output buffer
   // ********************************************************************

   // The controller cannot be stalled, so a word that meets a full buffer
   // is dropped and the sticky overflow flag records it.
   logic [`PBM_WORD_W:0]     skid;
   logic                     skid_valid;
   logic                     pop;
   logic                     drain;
   logic                     accept;

   // A word arriving while the skid entry drains is kept, so only a
   // genuinely full buffer loses data.
   assign pop    = o_pixel_valid & i_pixel_ready;
   assign drain  = ~o_pixel_valid | pop;
   assign accept = word_push & (drain | ~skid_valid);

   always_ff @(posedge i_core_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_pixel_data   <= '0;
         o_pixel_active <= 1'b0;
         o_pixel_valid  <= 1'b0;
         skid           <= '0;
         skid_valid     <= 1'b0;
      end else if (drain) begin
         if (skid_valid) begin
            {o_pixel_active, o_pixel_data} <= skid;
            o_pixel_valid                  <= 1'b1;
            skid                           <= {word_de, word};
            skid_valid                     <= word_push;
         end else begin
            {o_pixel_active, o_pixel_data} <= {word_de, word};
            o_pixel_valid                  <= word_push;
         end
      end else if (accept) begin
         skid       <= {word_de, word};
         skid_valid <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_overflow <= 1'b0;
      end else if (word_push && !accept) begin
         o_overflow <= 1'b1;
      end
   end

endmodule : pbm_pixel_bus_input_mux

//--- sim/pbm_mux_assertions.sv
// Concurrent checks on the ports of the pixel bus input mux.
// Assumes static pins settle within a few core cycles of a change.
`timescale 1ns/1ns
`include "pbm_defines.svh"

module pbm_mux_chk (
   input logic                   i_core_clk, i_rst_b, i_active_video_flag,
   input logic                   i_bus_width_select, i_serial_port_select,
   input logic                   i_skew_adjust_enable, i_pixel_ready,
   input logic                   i_multifunction_input_1,
   input logic                   i_multifunction_input_2,
   input logic                   i_multifunction_input_3,
   input logic [`PBM_WORD_W-1:0] i_data, o_pixel_data,
   input logic                   o_pixel_valid, o_sideband_valid,
   input logic [`PBM_CTL_W-1:0]  o_sideband_control_bits,
   input logic [`PBM_SKEW_W-1:0] o_skew_code, o_slave_addr_lsb,
   input logic [`PBM_CFG_W-1:0]  o_user_config_byte
);
   logic [2:0] mf;
   logic       side;
   assign mf   = {i_multifunction_input_3, i_multifunction_input_2,
                  i_multifunction_input_1};
   assign side = !i_serial_port_select && !i_skew_adjust_enable;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   // **********************************************************
   // Eight quiet cycles cover the pin synchronisers and the output flop.
   // **********************************************************
   sequence side_held;
      (side && !i_active_video_flag && $stable(mf[1:0]))[*8];
   endsequence
   sequence skew_held;
      (!i_serial_port_select && i_skew_adjust_enable && $stable(mf))[*8];
   endsequence
   sequence addr_held;
      (i_serial_port_select && $stable(mf))[*8];
   endsequence
   sequence noskew_held;
      (i_serial_port_select || !i_skew_adjust_enable)[*8];
   endsequence
   sequence narrow_held;
      (!i_bus_width_select && $stable(i_data[23:16]))[*8];
   endsequence

   chk_side_bits: assert property (side_held |->
      o_sideband_valid && o_sideband_control_bits == mf[1:0])
      else $error("sideband bits");
   chk_side_frozen: assert property (i_active_video_flag[*8] |->
      !o_sideband_valid && $stable(o_sideband_control_bits))
      else $error("sideband not frozen");
   chk_skew_code: assert property (skew_held |-> o_skew_code == mf)
      else $error("skew code");
   chk_skew_off: assert property (noskew_held |-> o_skew_code == 3'h0)
      else $error("skew code not cleared");
   chk_addr_bits: assert property (addr_held |->
      o_slave_addr_lsb == mf && o_skew_code == 3'h0)
      else $error("address bits");
   chk_user_byte: assert property (narrow_held |->
      o_user_config_byte == i_data[23:16]) else $error("user byte");
   chk_byte_hold: assert property (i_bus_width_select[*8] |=>
      $stable(o_user_config_byte)) else $error("user byte moved");
   chk_word_hold: assert property (o_pixel_valid && !i_pixel_ready |=>
      o_pixel_valid && $stable(o_pixel_data)) else $error("word dropped");
endmodule : pbm_mux_chk

bind pbm_pixel_bus_input_mux pbm_mux_chk i_pbm_mux_chk (.*);

//--- sim/pbm_gfx_model.sv
// Graphics controller model driving the pixel bus and its clock.
// Assumes send is called just after a falling core clock edge.
`timescale 1ns/1ns

module pbm_gfx_model (
   output logic        o_link_clk,  // Pixel input clock.
   output logic [23:0] o_data,      // Pixel bus.
   output logic        o_active     // Active video flag.
);
   initial begin
      o_link_clk = 1'b0;
      o_data     = 24'h000000;
      o_active   = 1'b0;
   end

   // **********************************************************
   // One pixel; the clock stands still low between pixels.
   // **********************************************************
   // Halves turn over mid half-period so each edge sees a settled bus.
   task automatic send(input logic wide, input logic [23:0] w,
                       input logic [7:0] user, input logic act);
      o_active = act;
      o_data   = wide ? w : {user, w[23:20], w[11:0]};
      #80 o_link_clk = 1'b1;
      #80 if (!wide) o_data[11:0] = w[23:12];
      #80 o_link_clk = 1'b0;
      // Released lines show the inverse so stale data is never matched.
      #40 o_data = wide ? ~o_data : {o_data[23:12], ~o_data[11:0]};
      #40;
   endtask : send
endmodule : pbm_gfx_model

//--- sim/pbm_pixel_bus_input_mux_tb.sv
// Self-checking bench for the pixel bus input mux.
// Assumes the checker is bound in and the model drives the pixel bus.
`timescale 1ns/1ns

module pbm_pixel_bus_input_mux_tb;
   logic        clk = 1'b0, rst_b = 1'b0, ready = 1'b1, stall = 1'b0;
   logic        bw = 1'b1, ser = 1'b0, skw = 1'b0, mf1 = 1'b0, mf2 = 1'b0;
   logic        mf3 = 1'b0, mf3_oe = 1'b1, lclk, act, vld, ovf, sbv, pact;
   logic        actq[$];
   logic [4:0]  rnd;
   tri0         mf3_pin;
   logic [23:0] din, dout, expq[$];
   logic [1:0]  sb, sbx = 2'h0;
   logic [2:0]  skc, adr, exp3;
   logic [7:0]  ucb, ucb_exp = 8'h00;
   int          miscompares = 0, tests_run = 0, seed = 18;

   assign mf3_pin = mf3_oe ? mf3 : 1'bz;
   always #20 clk = ~clk;
   always @(negedge clk) ready <= stall ? 1'b0 : ($random(seed) % 4 != 0);

   pbm_gfx_model i_pbm_gfx_model (.o_link_clk(lclk), .o_data(din),
      .o_active(act));
   pbm_pixel_bus_input_mux i_pbm_pixel_bus_input_mux (.i_core_clk(clk),
      .i_rst_b(rst_b), .i_pixel_input_clock(lclk), .i_data(din),
      .i_active_video_flag(act), .i_bus_width_select(bw),
      .i_serial_port_select(ser), .i_skew_adjust_enable(skw),
      .i_multifunction_input_1(mf1), .i_multifunction_input_2(mf2),
      .i_multifunction_input_3(mf3_pin), .i_pixel_ready(ready),
      .o_pixel_data(dout), .o_pixel_active(pact), .o_pixel_valid(vld),
      .o_overflow(ovf), .o_sideband_control_bits(sb),
      .o_sideband_valid(sbv), .o_skew_code(skc),
      .o_slave_addr_lsb(adr), .o_user_config_byte(ucb));

   // **********************************************************
   // Checking helpers
   // **********************************************************
   function automatic logic [23:0] pair_halves(logic [11:0] r, f);
      return {f, r};
   endfunction : pair_halves

   task automatic chk(input string what, input logic [23:0] e, g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic close_out;
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   task automatic burst(input logic wide, input int n);
      logic [23:0] w;
      logic        a;
      for (int k = 0; k < n; k++) begin
         w = (k == 0) ? {24{wide}} : 24'($random(seed));
         a = (k == 0) | 1'($random(seed));
         expq.push_back(wide ? w : pair_halves(w[11:0], w[23:12]));
         actq.push_back(a);
         i_pbm_gfx_model.send(wide, w, ucb_exp, a);
      end
   endtask : burst

   always @(posedge clk) begin
      if (rst_b && vld === 1'b1 && ready === 1'b1) begin
         chk("word", expq.pop_front(), dout);
         chk("pixel flag", 24'(actq.pop_front()), 24'(pact));
      end
   end

   initial begin
      #100000;
      miscompares++;
      close_out();
   end

   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      burst(1'b1, 12);
      bw = 1'b0;
      ucb_exp = 8'($random(seed));
      repeat (8) @(negedge clk);
      burst(1'b0, 12);
      repeat (20) @(negedge clk);
      chk("user byte", 24'(ucb_exp), 24'(ucb));
      chk("words left", 24'h0, 24'(expq.size()));
      chk("overflow", 24'h0, 24'(ovf));
      for (int m = 0; m < 12; m++) begin
         rnd = 5'($random(seed));
         if (m < 8) rnd[4:3] = 2'(m);
         {ser, skw, mf3, mf2, mf1} = rnd;
         mf3_oe = (m != 2);
         i_pbm_gfx_model.o_active = (m == 4) || (m > 7 && mf1);
         repeat (10) @(negedge clk);
         exp3 = {mf3_oe & mf3, mf2, mf1};
         if (!ser && !skw && !act) sbx = exp3[1:0];
         if (ser) chk("address bits", 24'(exp3), 24'(adr));
         chk("skew code", (!ser && skw) ? 24'(exp3) : 24'h0, 24'(skc));
         if (!ser && !skw) begin
            chk("sideband", {22'h0, sbx}, 24'(sb));
            chk("sideband ok", 24'(!act), 24'(sbv));
         end
      end
      // Skew code 4 moves the capture late in the window but inside it.
      {ser, skw, mf3, mf2, mf1, bw} = 6'b011001;
      repeat (8) @(negedge clk);
      burst(1'b1, 6);
      repeat (20) @(negedge clk);
      chk("skewed words left", 24'h0, 24'(expq.size()));
      chk("skew in use", 24'h4, 24'(skc));
      {ser, skw, mf3_oe, bw, stall} = 5'b00111;
      repeat (8) @(negedge clk);
      for (int k = 0; k < 4; k++) begin
         i_pbm_gfx_model.send(1'b1, 24'(k), 8'h0, 1'b1);
      end
      repeat (8) @(negedge clk);
      chk("overflow", 24'h1, 24'(ovf));
      close_out();
   end
endmodule : pbm_pixel_bus_input_mux_tb
